// ==== mdu_top.v ====
`timescale 1ns/1ps
`include "mdu_defines.vh"

// How it works
// - 8-bit control: mode bit7, start bit0, zeros
// - control takes single-bit and byte writes
// - mode 0 multiplies, mode 1 divides
// - start bit settable only in division mode
// - start begins division, reads 1, self-clears
// - software clear ignored while dividing
// - multiply starts after both A halves written
// - product ready one clock after start
// - product low to B low, high to B high
// - division completes within 16 clocks
// - completion clears start and raises interrupt together
// - quotient overwrites A registers
// - remainder goes to C registers
// - 16x16 product, 32/32 quotient and remainder
// - six data registers reset to zero
module mdu_top (
  // clock and reset
  input  wire        clk_i,
  input  wire        reset_n_i,
  // register port from the processor
  input  wire [19:0] sfr_addr_i,
  input  wire [15:0] sfr_wdata_i,
  input  wire        sfr_wr_i,
  input  wire        sfr_bit_wr_i,
  input  wire [2:0]  sfr_bit_sel_i,
  input  wire        sfr_rd_i,
  output reg  [15:0] sfr_rdata_o,
  // interrupt request
  output reg         division_done_irq_o
);

  reg        rst_meta;
  reg        rst_n;
  reg        op_mode_select;
  reg        division_start_flag;
  reg [15:0] operand_a_low;
  reg [15:0] operand_a_high;
  reg [15:0] operand_b_low;
  reg [15:0] operand_b_high;
  reg [15:0] remainder_low;
  reg [15:0] remainder_high;
  reg        a_low_loaded;
  reg        a_high_loaded;
  reg        next_mode;
  reg        next_start;
  reg        div_start;
  reg [15:0] read_value;

  wire        div_done;
  wire [31:0] div_quotient;
  wire [31:0] div_remainder;
  wire [31:0] product;
  wire        ctrl_wr;
  wire        mul_fire;

  // reset release through two flops
  always @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end
    else
    begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // unsigned 16x16 product
  assign product  = operand_a_high * operand_a_low;
  assign ctrl_wr  = (sfr_wr_i || sfr_bit_wr_i) && (sfr_addr_i == `MDU_ADDR_CTRL);
  assign mul_fire = a_low_loaded && a_high_loaded && !op_mode_select;

  // control register next value from byte or bit writes
  always @*
  begin
    next_mode  = op_mode_select;
    next_start = 1'b0;
    if (ctrl_wr && sfr_wr_i)
    begin
      next_mode  = sfr_wdata_i[7];
      next_start = sfr_wdata_i[0];
    end
    else if (ctrl_wr && sfr_bit_wr_i)
    begin
      if (sfr_bit_sel_i == `MDU_CTRL_MODE_BIT)
      begin
        next_mode = sfr_wdata_i[0];
      end
      else if (sfr_bit_sel_i == `MDU_CTRL_START_BIT)
      begin
        next_start = sfr_wdata_i[0];
      end
    end
    // start only taken in division mode and when idle
    div_start = next_start && next_mode && !division_start_flag;
  end

  // control register; start flag only cleared by completion
  always @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      op_mode_select      <= 1'b0;
      division_start_flag <= 1'b0;
      division_done_irq_o <= 1'b0;
    end
    else
    begin
      division_done_irq_o <= div_done;
      if (ctrl_wr)
      begin
        op_mode_select <= next_mode;
      end
      if (div_start)
      begin
        division_start_flag <= 1'b1;
      end
      else if (div_done)
      begin
        division_start_flag <= 1'b0;
      end
    end
  end

  // data registers: software loads, hardware results take priority
  always @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      operand_a_low  <= `MDU_DATA_RESET;
      operand_a_high <= `MDU_DATA_RESET;
      operand_b_low  <= `MDU_DATA_RESET;
      operand_b_high <= `MDU_DATA_RESET;
      remainder_low  <= `MDU_DATA_RESET;
      remainder_high <= `MDU_DATA_RESET;
      a_low_loaded   <= 1'b0;
      a_high_loaded  <= 1'b0;
    end
    else
    begin
      // operand loads made in division mode never arm a multiply
      if (mul_fire || op_mode_select)
      begin
        a_low_loaded  <= 1'b0;
        a_high_loaded <= 1'b0;
      end
      if (sfr_wr_i && sfr_addr_i == `MDU_ADDR_A_LOW)
      begin
        operand_a_low <= sfr_wdata_i;
        a_low_loaded  <= 1'b1;
      end
      else if (sfr_wr_i && sfr_addr_i == `MDU_ADDR_A_HIGH)
      begin
        operand_a_high <= sfr_wdata_i;
        a_high_loaded  <= 1'b1;
      end
      else if (sfr_wr_i && sfr_addr_i == `MDU_ADDR_B_LOW)
      begin
        operand_b_low <= sfr_wdata_i;
      end
      else if (sfr_wr_i && sfr_addr_i == `MDU_ADDR_B_HIGH)
      begin
        operand_b_high <= sfr_wdata_i;
      end
      // product lands one clock after the second operand write
      if (mul_fire)
      begin
        operand_b_low  <= product[15:0];
        operand_b_high <= product[31:16];
      end
      // division results overwrite dividend and fill remainder
      if (div_done)
      begin
        operand_a_low  <= div_quotient[15:0];
        operand_a_high <= div_quotient[31:16];
        remainder_low  <= div_remainder[15:0];
        remainder_high <= div_remainder[31:16];
      end
    end
  end

  // read decode; unmapped addresses read zero
  always @*
  begin
    if (sfr_addr_i == `MDU_ADDR_CTRL)
    begin
      read_value = {8'h00, op_mode_select, 6'h00, division_start_flag};
    end
    else if (sfr_addr_i == `MDU_ADDR_A_LOW)
    begin
      read_value = operand_a_low;
    end
    else if (sfr_addr_i == `MDU_ADDR_A_HIGH)
    begin
      read_value = operand_a_high;
    end
    else if (sfr_addr_i == `MDU_ADDR_B_LOW)
    begin
      read_value = operand_b_low;
    end
    else if (sfr_addr_i == `MDU_ADDR_B_HIGH)
    begin
      read_value = operand_b_high;
    end
    else if (sfr_addr_i == `MDU_ADDR_REM_LOW)
    begin
      read_value = remainder_low;
    end
    else if (sfr_addr_i == `MDU_ADDR_REM_HIGH)
    begin
      read_value = remainder_high;
    end
    else
    begin
      read_value = 16'h0000;
    end
  end

  // registered read data, held until the next read
  always @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sfr_rdata_o <= 16'h0000;
    end
    else if (sfr_rd_i)
    begin
      sfr_rdata_o <= read_value;
    end
  end

  // iterative divider, 16 clocks
  mdu_divider u_divider (
    .clk_i       (clk_i),
    .reset_n_i   (rst_n),
    .start_i     (div_start),
    .dividend_i  ({operand_a_high, operand_a_low}),
    .divisor_i   ({operand_b_high, operand_b_low}),
    .done_o      (div_done),
    .quotient_o  (div_quotient),
    .remainder_o (div_remainder)
  );

endmodule // mdu_top

// ==== mdu_defines.vh ====
`ifndef MDU_DEFINES_VH
`define MDU_DEFINES_VH

// register addresses on the peripheral register port
`define MDU_ADDR_CTRL      20'hF_00E8
`define MDU_ADDR_A_LOW     20'hF_00F0
`define MDU_ADDR_A_HIGH    20'hF_00F2
`define MDU_ADDR_B_LOW     20'hF_00F4
`define MDU_ADDR_B_HIGH    20'hF_00F6
`define MDU_ADDR_REM_LOW   20'hF_00F8
`define MDU_ADDR_REM_HIGH  20'hF_00FA

// control register fields
`define MDU_CTRL_MODE_BIT  3'h7
`define MDU_CTRL_START_BIT 3'h0

// reset values
`define MDU_CTRL_RESET     8'h00
`define MDU_DATA_RESET     16'h0000

// timing: clocks per division, two quotient bits per clock
`define MDU_DIV_CYCLES     5'h10

`endif

// ==== mdu_divider.v ====
`timescale 1ns/1ps
`include "mdu_defines.vh"

module mdu_divider (
  // clock and reset
  input  wire        clk_i,
  input  wire        reset_n_i,
  // request
  input  wire        start_i,
  input  wire [31:0] dividend_i,
  input  wire [31:0] divisor_i,
  // answer
  output reg         done_o,
  output reg  [31:0] quotient_o,
  output reg  [31:0] remainder_o
);

  reg        busy;
  reg [4:0]  count;
  reg [31:0] divisor;
  reg [63:0] next_rq;
  reg [63:0] first_rq;

  // one restoring step on {remainder, quotient}, all unsigned
  function [63:0] div_step;
    input [63:0] rq;
    input [31:0] d;
    reg   [32:0] shifted;
    begin
      shifted = rq[63:31];
      if (shifted >= {1'b0, d})
      begin
        div_step = {shifted[31:0] - d, rq[30:0], 1'b1};
      end
      else
      begin
        div_step = {shifted[31:0], rq[30:0], 1'b0};
      end
    end
  endfunction

  // two steps per clock; the start edge already takes the first two bits,
  // so the last bits land 15 clocks later and the top loads on the 16th
  always @*
  begin
    next_rq  = div_step(div_step({remainder_o, quotient_o}, divisor), divisor);
    first_rq = div_step(div_step({32'h0000_0000, dividend_i}, divisor_i), divisor_i);
  end

  // iteration control; the result registers double as the working state
  always @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      busy        <= 1'b0;
      count       <= 5'h00;
      divisor     <= 32'h0000_0000;
      done_o      <= 1'b0;
      quotient_o  <= 32'h0000_0000;
      remainder_o <= 32'h0000_0000;
    end
    else
    begin
      done_o <= 1'b0;
      if (start_i && !busy)
      begin
        busy        <= 1'b1;
        count       <= `MDU_DIV_CYCLES - 5'h01;
        divisor     <= divisor_i;
        {remainder_o, quotient_o} <= first_rq; // first two steps on the start edge
      end
      else if (busy)
      begin
        {remainder_o, quotient_o} <= next_rq;
        count <= count - 5'h01;
        if (count == 5'h01)
        begin
          busy   <= 1'b0;
          done_o <= 1'b1; // last step lands with this pulse
        end
      end
    end
  end

endmodule // mdu_divider

// ==== mdu_top_properties.sv ====
`timescale 1ns/1ps
`include "mdu_defines.vh"
module mdu_props (
  // watched ports
  input wire        clk_i,
  input wire        reset_n_i,
  input wire [19:0] sfr_addr_i,
  input wire [15:0] sfr_wdata_i,
  input wire        sfr_wr_i,
  input wire        sfr_bit_wr_i,
  input wire [2:0]  sfr_bit_sel_i,
  input wire        sfr_rd_i,
  input wire [15:0] sfr_rdata_o,
  input wire        division_done_irq_o
);
  default clocking dc @(posedge clk_i);
  endclocking
  default disable iff (!reset_n_i);
  // control reads and any write that tries to set the start bit
  wire ct = sfr_addr_i == `MDU_ADDR_CTRL;
  wire rc = sfr_rd_i && ct;
  wire sb = sfr_bit_wr_i && sfr_bit_sel_i == 3'h0;
  wire st = ct && sfr_wdata_i[0] && (sfr_wr_i || sb);
  wire sy = sfr_wr_i && ct && sfr_wdata_i[7:0] == 8'h81;
  property p_rst; $rose(reset_n_i) |-> (sfr_rdata_o == 16'h0000 && !division_done_irq_o) [*2];
  endproperty
  a_rst: assert property (p_rst) else $error("not quiet after reset");
  property p_zero; rc |=> (sfr_rdata_o & 16'hFF7E) == 16'h0000; endproperty
  a_zero: assert property (p_zero) else $error("control spare bits set");
  property p_unm; sfr_rd_i && sfr_addr_i[19:8] != 12'hF00 |=> sfr_rdata_o == 16'h0000; endproperty
  a_unm: assert property (p_unm) else $error("unmapped read not zero");
  property p_hold; !sfr_rd_i |=> $stable(sfr_rdata_o); endproperty
  a_hold: assert property (p_hold) else $error("read data moved");
  // done is set 16 clocks after the start edge and sampled one clock later
  property p_cause; division_done_irq_o |-> $past(st, 17); endproperty
  a_cause: assert property (p_cause) else $error("done not 17 after start");
  property p_pulse; division_done_irq_o |=> !division_done_irq_o [*8]; endproperty
  a_pulse: assert property (p_pulse) else $error("done not a lone pulse");
  property p_busy; sy ##2 rc |=> sfr_rdata_o == 16'h0081; endproperty
  a_busy: assert property (p_busy) else $error("busy not shown");
  property p_clr; $past(division_done_irq_o) && rc |=> !sfr_rdata_o[0]; endproperty
  a_clr: assert property (p_clr) else $error("start left set at done");
endmodule // mdu_props
bind mdu_top mdu_props i_mdu_props (.clk_i(clk_i), .reset_n_i(reset_n_i),
  .sfr_addr_i(sfr_addr_i), .sfr_wdata_i(sfr_wdata_i), .sfr_wr_i(sfr_wr_i),
  .sfr_bit_wr_i(sfr_bit_wr_i), .sfr_bit_sel_i(sfr_bit_sel_i), .sfr_rd_i(sfr_rd_i),
  .sfr_rdata_o(sfr_rdata_o), .division_done_irq_o(division_done_irq_o));

// ==== mdu_cpu_model.sv ====
`timescale 1ns/1ps
module mdu_cpu (
  // bus from the processor
  input  wire        clk_i,
  input  wire [15:0] rdata_i,
  output reg  [19:0] addr_o,
  output reg  [15:0] wdata_o,
  output reg         wr_o,
  output reg         bit_wr_o,
  output reg  [2:0]  sel_o,
  output reg         rd_o
);
  // idle bus at time zero
  initial {addr_o, wdata_o, wr_o, bit_wr_o, sel_o, rd_o} = 0;
  // one strobe {wr, bit, rd}; a bit write takes its index from d[3:1]
  task cyc(input [2:0] k, input [19:0] a, input [15:0] d, output [15:0] q);
    begin
      @(posedge clk_i);
      #1;
      addr_o = a;
      wdata_o = d;
      sel_o = d[3:1];
      {wr_o, bit_wr_o, rd_o} = k;
      @(posedge clk_i);
      #1;
      q = rdata_i;
      {wr_o, bit_wr_o, rd_o} = 3'h0;
      wdata_o = ~d; // released data does not linger
    end
  endtask
endmodule // mdu_cpu

// ==== multiply_divide_unit_bench.sv ====
`timescale 1ns/1ps
`include "mdu_defines.vh"
module multiply_divide_unit_bench;
  reg          clk = 1'h0;
  reg          rst_n = 1'h0;
  wire [19:0]  ad;
  wire [15:0]  wd, rq;
  wire [2:0]   bs;
  wire         wr, bw, rd, irq;
  reg  [15:0]  q;
  reg  [128:0] row [0:5];
  reg          m;
  reg  [31:0]  x, y, e1, e2;
  integer      n_mismatch = 0, total_checks = 0, i, t;
  always #5 clk = ~clk;
  mdu_top i_mdu_top (.clk_i(clk), .reset_n_i(rst_n), .sfr_addr_i(ad), .sfr_wdata_i(wd),
    .sfr_wr_i(wr), .sfr_bit_wr_i(bw), .sfr_bit_sel_i(bs), .sfr_rd_i(rd),
    .sfr_rdata_o(rq), .division_done_irq_o(irq));
  mdu_cpu i_mdu_cpu (.clk_i(clk), .rdata_i(rq), .addr_o(ad), .wdata_o(wd), .wr_o(wr),
    .bit_wr_o(bw), .sel_o(bs), .rd_o(rd));
  task chk(input [31:0] s, input [31:0] e);
    begin
      total_checks = total_checks + 1;
      if (s !== e)
      begin
        n_mismatch = n_mismatch + 1;
        $display("[ERR] %0t seen %h want %h", $time, s, e);
      end
    end
  endtask
  task w(input [19:0] a, input [15:0] d);
    i_mdu_cpu.cyc(3'h4, a, d, q);
  endtask
  task b(input [15:0] d);
    i_mdu_cpu.cyc(3'h2, `MDU_ADDR_CTRL, d, q);
  endtask
  task r(input [19:0] a, input [15:0] e);
    begin
      i_mdu_cpu.cyc(3'h1, a, 16'h0000, q);
      chk(q, e);
    end
  endtask
  // reset, then every register reads zero
  task rst_zero;
    begin
      rst_n = 1'h0;
      repeat (3) @(posedge clk);
      #1 rst_n = 1'h1;
      repeat (3) @(posedge clk);
      r(`MDU_ADDR_CTRL, 16'h0000);
      for (i = 0; i < 6; i = i + 1)
        r(20'(`MDU_ADDR_A_LOW + 2 * i), 16'h0000);
    end
  endtask
  task tally_and_finish;
    begin
      if (n_mismatch == 0 && total_checks > 0)
        $display("TB: PASS");
      else
        $display("TB: FAIL");
      $finish;
    end
  endtask
  // watchdog against a hang
  initial
  begin
    #100000;
    n_mismatch = n_mismatch + 1;
    tally_and_finish;
  end
  // rows: mode, first operand, second operand, first result, remainder
  initial
  begin
    row[0] = {1'h0, 32'h0003_0002, 32'h0000_0000, 32'h0000_0006, 32'h0000_0000};
    row[1] = {1'h1, 32'h0000_0023, 32'h0000_0006, 32'h0000_0005, 32'h0000_0005};
    row[2] = {1'h0, 32'hFFFF_FFFF, 32'h0000_0000, 32'hFFFE_0001, 32'h0000_0000};
    row[3] = {1'h1, 32'hFFFF_FFFF, 32'h0000_0010, 32'h0FFF_FFFF, 32'h0000_000F};
    row[4] = {1'h1, 32'h1234_5678, 32'h0001_0000, 32'h0000_1234, 32'h0000_5678};
    row[5] = {1'h1, 32'h0000_0005, 32'hFFFF_FFFF, 32'h0000_0000, 32'h0000_0005};
    rst_zero;
    for (i = 0; i < 6; i = i + 1)
    begin
      {m, x, y, e1, e2} = row[i];
      b({12'h000, 3'h7, m}); // mode set by a single-bit write
      if (!m)
      begin
        // operand halves in either order, product read at once
        if (i == 0)
          w(`MDU_ADDR_A_LOW, x[15:0]);
        w(`MDU_ADDR_A_HIGH, x[31:16]);
        if (i != 0)
          w(`MDU_ADDR_A_LOW, x[15:0]);
        r(`MDU_ADDR_B_HIGH, e1[31:16]);
        r(`MDU_ADDR_B_LOW, e1[15:0]);
      end
      else
      begin
        // operands first, nonzero divisor, mode left alone
        w(`MDU_ADDR_A_HIGH, x[31:16]);
        w(`MDU_ADDR_A_LOW, x[15:0]);
        w(`MDU_ADDR_B_HIGH, y[31:16]);
        w(`MDU_ADDR_B_LOW, y[15:0]);
        if (i[0])
          w(`MDU_ADDR_CTRL, 16'h0081);
        else
          b(16'h0001);
        r(`MDU_ADDR_CTRL, 16'h0081);
        b(16'h0000);
        r(`MDU_ADDR_CTRL, 16'h0081);
        // only control is read while busy
        t = 0;
        while (irq !== 1'h1 && t < 30)
        begin
          @(posedge clk);
          #1 t = t + 1;
        end
        // done within 16 clocks of the start edge; six edges passed before counting
        chk(t, 16 - 6);
        r(`MDU_ADDR_CTRL, 16'h0080);
        r(`MDU_ADDR_A_LOW, e1[15:0]);
        r(`MDU_ADDR_A_HIGH, e1[31:16]);
        r(`MDU_ADDR_REM_LOW, e2[15:0]);
        r(`MDU_ADDR_REM_HIGH, e2[31:16]);
      end
    end
    // start refused in multiply mode, spare bits stay zero
    b(16'h000E);
    w(`MDU_ADDR_CTRL, 16'h0001);
    r(`MDU_ADDR_CTRL, 16'h0000);
    b(16'h0001);
    r(`MDU_ADDR_CTRL, 16'h0000);
    w(`MDU_ADDR_CTRL, 16'h007E);
    r(`MDU_ADDR_CTRL, 16'h0000);
    r(20'h0_1234, 16'h0000);
    rst_zero;
    tally_and_finish;
  end
endmodule // multiply_divide_unit_bench
